// File: hdl/aotr_trim_regs.sv
// How it works
// - 12-bit converter 5 offset trim drives output
// - Converter 0 fine gain at 0x360
// - Converter 1 fine gain at 0x361
// - 0x362 gain used while converter 2 samples A
// - 0x363 gain used while converter 2 samples B
// - 0x364 gain used while converter 3 samples C
// - 0x365 gain used while converter 3 samples D
// - Converter 4 fine gain at 0x366
// - Gain defaults load from fuse storage
//
// Implementation choice: register access over APB.
module aotr_trim_regs
  import aotr_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          srst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [13:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [NUM_GAIN*GAIN_W-1:0]    fuse_gain,
  input  wire logic                          adc2_on_pair_b,
  input  wire logic                          adc3_on_pair_d,
  output logic      [OFS_W-1:0]              adc5_offset,
  output logic      [GAIN_W-1:0]             adc0_gain,
  output logic      [GAIN_W-1:0]             adc1_gain,
  output logic      [GAIN_W-1:0]             adc2_gain,
  output logic      [GAIN_W-1:0]             adc3_gain,
  output logic      [GAIN_W-1:0]             adc4_gain
);

  logic [GAIN_REG_W-1:0] gain_r [NUM_GAIN];
  logic [OFS_REG_W-1:0]  ofs_r;
  logic                  fuse_load_r;
  logic [NUM_GAIN*GAIN_W-1:0] fuse_s1_r;
  logic [NUM_GAIN*GAIN_W-1:0] fuse_s2_r;
  logic [1:0]            sel_s1_r;
  logic [1:0]            sel_s2_r;
  logic                  setup;
  logic                  wr_en;
  logic                  rd_en;
  logic [11:0]           idx;
  logic                  word_ok;
  logic                  is_ofs;
  logic                  is_gain;
  logic [2:0]            gsel;
  logic [31:0]           rd_nxt;

  assign setup   = psel && !penable;
  assign idx     = paddr[13:2];
  assign word_ok = (paddr[1:0] == 2'b00);
  assign is_ofs  = word_ok && (idx == IDX_ADC5_OFS);
  assign is_gain = word_ok && (idx >= IDX_ADC0_GAIN)
                   && (idx <= IDX_ADC4_GAIN);
  assign gsel    = 3'(idx - IDX_ADC0_GAIN);
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_en   = setup && !pwrite;

  // Fuse values and pair selects come from other domains
  always_ff @(posedge clock) begin
    fuse_s1_r <= fuse_gain;
    fuse_s2_r <= fuse_s1_r;
    sel_s1_r  <= {adc3_on_pair_d, adc2_on_pair_b};
    sel_s2_r  <= sel_s1_r;
  end

  // Load fuse defaults once after reset release
  always_ff @(posedge clock) begin
    if (srst) begin
      fuse_load_r <= 1'b1;
    end else begin
      fuse_load_r <= 1'b0;
    end
  end

  // Gain registers, byte lane 0 only; reserved bits stored as written
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_GAIN; i++) begin
      if (srst) begin
        gain_r[i] <= GAIN_RSV_RESET;
      end else if (fuse_load_r) begin
        gain_r[i] <= {3'b000, fuse_s2_r[i*GAIN_W +: GAIN_W]};
      end else if (wr_en && is_gain && gsel == 3'(i) && pstrb[0]) begin
        gain_r[i] <= pwdata[GAIN_REG_W-1:0];
      end
    end
  end

  // Offset register for converter 5
  always_ff @(posedge clock) begin
    if (srst) begin
      ofs_r <= OFS_RESET;
    end else if (wr_en && is_ofs) begin
      if (pstrb[0]) begin
        ofs_r[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        ofs_r[15:8] <= pwdata[15:8];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_nxt = RDATA_ZERO;
    if (is_ofs) begin
      rd_nxt = {16'h0000, ofs_r};
    end else if (is_gain) begin
      rd_nxt = {24'h000000, gain_r[gsel]};
    end
  end

  // APB slave: no wait states, unmapped access raises pslverr
  always_ff @(posedge clock) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RDATA_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(is_ofs || is_gain);
      if (rd_en) begin
        prdata <= rd_nxt;
      end
    end
  end

  // Trim outputs to the conversion cores
  always_ff @(posedge clock) begin
    if (srst) begin
      adc5_offset <= '0;
      adc0_gain   <= '0;
      adc1_gain   <= '0;
      adc2_gain   <= '0;
      adc3_gain   <= '0;
      adc4_gain   <= '0;
    end else begin
      adc5_offset <= ofs_r[OFS_W-1:0];
      adc0_gain   <= gain_r[0][GAIN_W-1:0];
      adc1_gain   <= gain_r[1][GAIN_W-1:0];
      adc2_gain   <= sel_s2_r[0] ? gain_r[3][GAIN_W-1:0]
                                 : gain_r[2][GAIN_W-1:0];
      adc3_gain   <= sel_s2_r[1] ? gain_r[5][GAIN_W-1:0]
                                 : gain_r[4][GAIN_W-1:0];
      adc4_gain   <= gain_r[6][GAIN_W-1:0];
    end
  end

  a_ofs_drive: assert property (
    @(posedge clock) disable iff (srst)
    ##1 (adc5_offset == $past(ofs_r[OFS_W-1:0])))
    else $error("offset output does not follow register");

  a_adc0_fine_gain_drive: assert property (
    @(posedge clock) disable iff (srst)
    ##1 (adc0_gain == $past(gain_r[0][GAIN_W-1:0])))
    else $error("gain 0 output mismatch");

  a_adc1_fine_gain_drive: assert property (
    @(posedge clock) disable iff (srst)
    ##1 (adc1_gain == $past(gain_r[1][GAIN_W-1:0])))
    else $error("gain 1 output mismatch");

  a_pair_a_sel: assert property (
    @(posedge clock) disable iff (srst)
    !sel_s2_r[0] |=> (adc2_gain == $past(gain_r[2][GAIN_W-1:0])))
    else $error("pair A gain not applied");

  a_pair_b_sel: assert property (
    @(posedge clock) disable iff (srst)
    sel_s2_r[0] |=> (adc2_gain == $past(gain_r[3][GAIN_W-1:0])))
    else $error("pair B gain not applied");

  a_pair_c_sel: assert property (
    @(posedge clock) disable iff (srst)
    !sel_s2_r[1] |=> (adc3_gain == $past(gain_r[4][GAIN_W-1:0])))
    else $error("pair C gain not applied");

  a_pair_d_sel: assert property (
    @(posedge clock) disable iff (srst)
    sel_s2_r[1] |=> (adc3_gain == $past(gain_r[5][GAIN_W-1:0])))
    else $error("pair D gain not applied");

  a_adc4_fine_gain_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd6 && pstrb[0])
    |=> ##1 (adc4_gain == $past(pwdata[GAIN_W-1:0], 2)))
    else $error("gain 4 write not applied");

  a_fuse_load: assert property (
    @(posedge clock) disable iff (srst)
    (!srst && fuse_load_r)
    |=> (gain_r[0][GAIN_W-1:0] == $past(fuse_s2_r[GAIN_W-1:0])))
    else $error("fuse default not loaded");

  a_read_back: assert property (
    @(posedge clock) disable iff (srst)
    (rd_en && is_gain && gsel == 3'd0)
    |=> (pready && prdata[7:0] == $past(gain_r[0])))
    else $error("read data mismatch");

  a_ready_setup: assert property (
    @(posedge clock) disable iff (srst)
    setup |=> pready)
    else $error("no ready after setup");

  a_ready_single: assert property (
    @(posedge clock) disable iff (srst)
    pready |=> !pready)
    else $error("ready held too long");

  a_err_unmapped: assert property (
    @(posedge clock) disable iff (srst)
    (setup && !is_ofs && !is_gain) |=> (pready && pslverr))
    else $error("unmapped access not flagged");

  a_err_mapped: assert property (
    @(posedge clock) disable iff (srst)
    (setup && (is_ofs || is_gain)) |=> !pslverr)
    else $error("mapped access flagged");

  a_err_ready: assert property (
    @(posedge clock) disable iff (srst)
    pslverr |-> pready)
    else $error("error without ready");

  a_read_ofs: assert property (
    @(posedge clock) disable iff (srst)
    (rd_en && is_ofs) |=> (prdata == {16'h0000, $past(ofs_r)}))
    else $error("offset read mismatch");

  a_read_empty: assert property (
    @(posedge clock) disable iff (srst)
    (rd_en && !is_ofs && !is_gain) |=> (prdata == RDATA_ZERO))
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (
    @(posedge clock) disable iff (srst)
    !rd_en |=> $stable(prdata))
    else $error("read data changed without read");

  a_adc0_fine_gain_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd0 && pstrb[0] && !fuse_load_r)
    |=> (gain_r[0] == $past(pwdata[GAIN_REG_W-1:0])))
    else $error("gain 0 write not stored");

  a_adc1_fine_gain_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd1 && pstrb[0] && !fuse_load_r)
    |=> (gain_r[1] == $past(pwdata[GAIN_REG_W-1:0])))
    else $error("gain 1 write not stored");

  a_pair_a_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd2 && pstrb[0] && !fuse_load_r)
    |=> (gain_r[2] == $past(pwdata[GAIN_REG_W-1:0])))
    else $error("pair A gain write not stored");

  a_pair_b_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd3 && pstrb[0] && !fuse_load_r)
    |=> (gain_r[3] == $past(pwdata[GAIN_REG_W-1:0])))
    else $error("pair B gain write not stored");

  a_pair_c_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd4 && pstrb[0] && !fuse_load_r)
    |=> (gain_r[4] == $past(pwdata[GAIN_REG_W-1:0])))
    else $error("pair C gain write not stored");

  a_pair_d_write: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd5 && pstrb[0] && !fuse_load_r)
    |=> (gain_r[5] == $past(pwdata[GAIN_REG_W-1:0])))
    else $error("pair D gain write not stored");

  a_gain_strobe: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_gain && gsel == 3'd0 && !pstrb[0] && !fuse_load_r)
    |=> $stable(gain_r[0]))
    else $error("gain written without lane 0");

  a_ofs_low_lane: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_ofs && pstrb[0]) |=> (ofs_r[7:0] == $past(pwdata[7:0])))
    else $error("offset low lane not stored");

  a_ofs_high_lane: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_ofs && pstrb[1]) |=> (ofs_r[15:8] == $past(pwdata[15:8])))
    else $error("offset high lane not stored");

  a_ofs_low_keep: assert property (
    @(posedge clock) disable iff (srst)
    (wr_en && is_ofs && !pstrb[0]) |=> $stable(ofs_r[7:0]))
    else $error("offset low lane written without strobe");

  a_ofs_keep: assert property (
    @(posedge clock) disable iff (srst)
    !(wr_en && is_ofs) |=> $stable(ofs_r))
    else $error("offset changed without write");

  a_fuse_rsv_zero: assert property (
    @(posedge clock) disable iff (srst)
    (!srst && fuse_load_r)
    |=> (gain_r[NUM_GAIN-1][GAIN_REG_W-1:GAIN_W] == '0))
    else $error("reserved bits not cleared on load");

  a_fuse_load_last: assert property (
    @(posedge clock) disable iff (srst)
    (!srst && fuse_load_r) |=> (gain_r[NUM_GAIN-1][GAIN_W-1:0]
      == $past(fuse_s2_r[(NUM_GAIN-1)*GAIN_W +: GAIN_W])))
    else $error("last fuse default not loaded");

  a_load_once: assert property (
    @(posedge clock) disable iff (srst)
    (!srst && fuse_load_r) |=> !fuse_load_r)
    else $error("fuse load repeated");

  a_load_armed: assert property (
    @(posedge clock) disable iff (srst)
    $fell(srst) |-> fuse_load_r)
    else $error("fuse load missing after reset");

endmodule : aotr_trim_regs

// File: hdl/aotr_pkg.sv
package aotr_pkg;
  // Printed offsets are not all multiples of four: they are register indices
  localparam logic [11:0] IDX_ADC0_GAIN   = 12'h360;
  localparam logic [11:0] IDX_ADC1_GAIN   = 12'h361;
  localparam logic [11:0] IDX_ADC2A_GAIN  = 12'h362;
  localparam logic [11:0] IDX_ADC2B_GAIN  = 12'h363;
  localparam logic [11:0] IDX_ADC3C_GAIN  = 12'h364;
  localparam logic [11:0] IDX_ADC3D_GAIN  = 12'h365;
  localparam logic [11:0] IDX_ADC4_GAIN   = 12'h366;
  localparam logic [11:0] IDX_ADC5_OFS    = 12'h358;
  localparam int          NUM_GAIN        = 7;
  localparam int          GAIN_W          = 5;
  localparam int          GAIN_REG_W      = 8;
  localparam int          OFS_W           = 12;
  localparam int          OFS_REG_W       = 16;
  localparam logic [15:0] OFS_RESET       = 16'h0000;
  localparam logic [7:0]  GAIN_RSV_RESET  = 8'h00;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;
endpackage : aotr_pkg

// File: testbench/aotr_trim_regs_tb.sv
module aotr_trim_regs_tb
  import aotr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clock, srst, psel, penable, pwrite;
  logic [13:0]                paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic [3:0]                 pstrb;
  logic                       pready, pslverr, err;
  logic [NUM_GAIN*GAIN_W-1:0] fuse_gain;
  logic                       adc2_on_pair_b, adc3_on_pair_d;
  logic [OFS_W-1:0]           adc5_offset;
  logic [GAIN_W-1:0]          adc0_gain, adc1_gain, adc2_gain;
  logic [GAIN_W-1:0]          adc3_gain, adc4_gain;
  int                         n_errors, n_checks;

  aotr_trim_regs dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_gain(fuse_gain), .adc2_on_pair_b(adc2_on_pair_b),
    .adc3_on_pair_d(adc3_on_pair_d), .adc5_offset(adc5_offset),
    .adc0_gain(adc0_gain), .adc1_gain(adc1_gain), .adc2_gain(adc2_gain),
    .adc3_gain(adc3_gain), .adc4_gain(adc4_gain));

  function automatic logic [4:0] fz(input int i);
    return 5'(5'h0A + i);
  endfunction : fz

  function automatic logic [4:0] gv(input int i);
    return 5'(5'h15 + i);
  endfunction : gv

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd, input logic [3:0] be = 4'hF);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= be;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #(20 * 5000);
    n_errors++;
    wrap_up();
  end

  initial begin
    n_errors = 0; n_checks = 0;
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 14'h0000; pwdata = 32'h0000_0000; pstrb = 4'h0;
    adc2_on_pair_b = 1'b0; adc3_on_pair_d = 1'b0;
    for (int i = 0; i < NUM_GAIN; i++) fuse_gain[i*5+:5] = fz(i);
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(adc0_gain), 32'(fz(0))); // Fuse default
    chk(32'(adc2_gain), 32'(fz(2))); // Pair A fuse default
    chk(32'(adc3_gain), 32'(fz(4))); // Pair C fuse default
    for (int i = 0; i < NUM_GAIN; i++) begin
      apb(1'b0, 12'(IDX_ADC0_GAIN + i), 32'h0000_0000);
      chk(rd, 32'(fz(i))); // Read of fuse value
    end
    for (int i = 0; i < NUM_GAIN; i++) // Reserved bits zero
      apb(1'b1, 12'(IDX_ADC0_GAIN + i), 32'(gv(i)));
    for (int i = 0; i < NUM_GAIN; i++) begin
      apb(1'b0, 12'(IDX_ADC0_GAIN + i), 32'h0000_0000);
      chk(rd, 32'(gv(i)));
    end
    chk(32'(adc0_gain), 32'(gv(0))); // Converter 0 gain
    chk(32'(adc1_gain), 32'(gv(1))); // Converter 1 gain
    chk(32'(adc4_gain), 32'(gv(6))); // Converter 4 gain
    chk(32'(adc2_gain), 32'(gv(2))); // Pair A gain
    chk(32'(adc3_gain), 32'(gv(4))); // Pair C gain
    adc2_on_pair_b <= 1'b1;
    adc3_on_pair_d <= 1'b1;
    repeat (5) @(posedge clock);
    chk(32'(adc2_gain), 32'(gv(3))); // Pair B gain
    chk(32'(adc3_gain), 32'(gv(5))); // Pair D gain
    apb(1'b1, IDX_ADC5_OFS, 32'h0000_0ABC); // Reserved bits zero
    apb(1'b0, IDX_ADC5_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0ABC); // Offset readback
    repeat (2) @(posedge clock);
    chk(32'(adc5_offset), 32'h0000_0ABC); // Offset applied
    apb(1'b1, IDX_ADC0_GAIN, 32'h0000_0001, 4'hE); // Lane 0 off
    apb(1'b0, IDX_ADC0_GAIN, 32'h0000_0000);
    chk(rd, 32'(gv(0))); // Gain kept without lane 0
    apb(1'b1, IDX_ADC5_OFS, 32'h0000_0D00, 4'h2); // Upper lane only
    apb(1'b0, IDX_ADC5_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0DBC); // Lane 1 merged
    repeat (2) @(posedge clock);
    chk(32'(adc5_offset), 32'h0000_0DBC); // Offset lane 1 applied
    apb(1'b1, 12'hFFF, 32'h0000_001F);
    chk(32'(err), 32'h0000_0001); // Unmapped write flagged
    apb(1'b0, 12'hFFF, 32'h0000_0000);
    chk(rd, 32'h0000_0000); // Unmapped read zero
    chk(32'(err), 32'h0000_0001); // Unmapped read flagged
    wrap_up();
  end
endmodule : aotr_trim_regs_tb
